/* verilog/async_serial_unit.sv */
// asynchronous serial transmitter/receiver with an ahb-lite register slave
`timescale 1ns/1ps
module async_serial_unit import async_serial_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic cpu_irq_mask,
  output logic irq
);
  function automatic reg_sel_t decode(input logic [11:0] a);
    case (a)
      OFS_FLAG_WORD: decode = SEL_FLAG;
      OFS_DATA_WINDOW: decode = SEL_DATA;
      OFS_CTL1: decode = SEL_CTL1;
      OFS_CTL2: decode = SEL_CTL2;
      OFS_COARSE_BAUD: decode = SEL_COARSE;
      OFS_RX_FINE: decode = SEL_RXF;
      OFS_TX_FINE: decode = SEL_TXF;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  // ticks of mclk per 16x baud tick
  function automatic logic [15:0] tick_div(input logic [7:0] fine, input logic [1:0] pr_sel,
                                           input logic [2:0] ex);
    logic [15:0] pr;
    case (pr_sel)
      2'd0: pr = PR_A;
      2'd1: pr = PR_B;
      2'd2: pr = PR_C;
      default: pr = PR_D;
    endcase
    if (fine != 8'h00) tick_div = {8'h00, fine};
    else tick_div = 16'((pr * CONV_PRE) << ex);
  endfunction : tick_div

  // ---------------- bus and software registers ----------------
  bus_ph_t ph_q, ph_d;
  ctl1_t ctl1_q, ctl1_d;
  ctl2_t ctl2_q, ctl2_d;
  coarse_t coarse_q, coarse_d;
  logic [7:0] rxf_q, rxf_d, txf_q, txf_d, hold_q, hold_d;
  logic armed_q, armed_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic acc, rd_flag, rd_data, wr_data, tx_clr, rx_clr, wake_evt;
  reg_sel_t sel;
  logic tx_buffer_empty_flag_q, tc_q, rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q, rx9_q;
  logic [7:0] rdr_q;
  flags_t flags;

  assign flags = '{tx_buffer_empty_flag: tx_buffer_empty_flag_q, tc: tc_q, rx_full_flag: rx_full_flag_q, idle: idle_q, ovr: ovr_q, nf: nf_q,
                   fe: fe_q, rsvd: 1'b0};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_comb begin
    sel = decode(haddr[11:0]);
    acc = hsel && htrans[1] && hready;
    rd_flag = acc && (sel == SEL_FLAG);
    rd_data = acc && !hwrite && (sel == SEL_DATA);
    wr_data = ph_q.valid && ph_q.write && (ph_q.sel == SEL_DATA);
    // write half of the clear sequence
    tx_clr = armed_q && wr_data;
    // read half of the clear sequence
    rx_clr = armed_q && rd_data;
    ph_d = '{valid: acc, write: hwrite, sel: sel};
    armed_d = armed_q;
    if (rd_flag) armed_d = 1'b1;
    else if (rd_data || wr_data) armed_d = 1'b0;
    hrdata_d = hrdata_q;
    if (acc && !hwrite) begin
      case (sel)
        SEL_FLAG: hrdata_d = {24'h0000_00, flags};
        SEL_DATA: hrdata_d = {24'h0000_00, rdr_q};
        SEL_CTL1: hrdata_d = {24'h0000_00, rx9_q, ctl1_q.tx9, 1'b0, ctl1_q.wl, ctl1_q.wake,
                              3'b000};
        SEL_CTL2: hrdata_d = {24'h0000_00, ctl2_q};
        SEL_COARSE: hrdata_d = {24'h0000_00, coarse_q};
        SEL_RXF: hrdata_d = {24'h0000_00, rxf_q};
        SEL_TXF: hrdata_d = {24'h0000_00, txf_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    coarse_d = coarse_q;
    rxf_d = rxf_q;
    txf_d = txf_q;
    hold_d = hold_q;
    // hardware wake clears the mute bit
    if (wake_evt) ctl2_d.mute = 1'b0;
    if (ph_q.valid && ph_q.write) begin
      case (ph_q.sel)
        SEL_CTL1: ctl1_d = '{rx9: 1'b0, tx9: hwdata[6], rsvd5: 1'b0, wl: hwdata[4],
                            wake: hwdata[3], rsvd: 3'b000};
        SEL_CTL2: ctl2_d = hwdata[7:0];
        SEL_COARSE: coarse_d = hwdata[7:0];
        SEL_RXF: rxf_d = hwdata[7:0];
        SEL_TXF: txf_d = hwdata[7:0];
        // data always lands in the holding buffer, even when it also goes straight to the shifter
        SEL_DATA: hold_d = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ph_q <= '{valid: 1'b0, write: 1'b0, sel: SEL_NONE};
      ctl1_q <= CTL_RESET;
      ctl2_q <= CTL_RESET;
      coarse_q <= BAUD_RESET;
      rxf_q <= BAUD_RESET;
      txf_q <= BAUD_RESET;
      hold_q <= 8'h00;
      armed_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ph_q <= ph_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      coarse_q <= coarse_d;
      rxf_q <= rxf_d;
      txf_q <= txf_d;
      hold_q <= hold_d;
      armed_q <= armed_d;
      hrdata_q <= hrdata_d;
    end
  end

  // interrupt from enabled flags unless the cpu masks it
  assign irq = !cpu_irq_mask && ((tx_buffer_empty_flag_q && ctl2_q.tx_empty_irq_on) || (tc_q && ctl2_q.tx_done_irq_on) ||
               ((rx_full_flag_q || ovr_q) && ctl2_q.rx_irq_on) || (idle_q && ctl2_q.line_quiet_irq_on));

  // ---------------- transmitter ----------------
  tx_state_t tx_st_q, tx_st_d;
  tx_kind_t tx_kind_q, tx_kind_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d, tx_sub_q, tx_sub_d, frame_bits;
  logic [15:0] tx_div_q, tx_div_d;
  logic pre_q, pre_d, te_prev_q, hold_full_q, hold_full_d, tx_buffer_empty_flag_d, tc_d, pin_d, oe_d;
  logic bit_edge, pick, tx_buffer_empty_flag_set, tc_set, direct;

  always_comb begin
    frame_bits = ctl1_q.wl ? FRAME_BITS_9 : FRAME_BITS_8;
    tx_st_d = tx_st_q;
    tx_kind_d = tx_kind_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_sub_d = tx_sub_q;
    pre_d = pre_q;
    hold_full_d = hold_full_q;
    tx_buffer_empty_flag_set = 1'b0;
    tc_set = 1'b0;
    pick = 1'b0;
    tx_div_d = tx_div_q - 16'h0001;
    if (tx_div_q == 16'h0000) begin
      tx_div_d = tick_div(txf_q, coarse_q.pr_sel, coarse_q.tx_exp) - 16'h0001;
      tx_sub_d = tx_sub_q + 4'h1;
    end
    bit_edge = (tx_div_q == 16'h0000) && (tx_sub_q == SUB_LAST);
    // a write to a resting transmitter bypasses the holding buffer
    direct = wr_data && tx_st_q == TX_REST && ctl2_q.tx_on && !pre_q && !ctl2_q.brk &&
             !hold_full_q;
    if (wr_data) hold_full_d = 1'b1;
    // enable dropped: holding content is discarded
    if (te_prev_q && !ctl2_q.tx_on) begin
      hold_full_d = 1'b0;
      tx_buffer_empty_flag_set = 1'b1;
    end
    // enable raised: one idle frame goes out first
    if (!te_prev_q && ctl2_q.tx_on) pre_d = 1'b1;
    case (tx_st_q)
      TX_OFF: begin
        if (ctl2_q.tx_on) tx_st_d = TX_REST;
      end
      TX_REST: begin
        if (!ctl2_q.tx_on) tx_st_d = TX_OFF;
        else if (bit_edge || direct) pick = 1'b1;
      end
      TX_SEND: begin
        if (bit_edge) begin
          if (tx_left_q == 4'h1) begin
            // done flag after data, idle or break frame
            tc_set = (tx_kind_q != K_EXTRA);
            pick = 1'b1;
          end else begin
            tx_sh_d = {1'b1, tx_sh_q[10:1]};
            tx_left_d = tx_left_q - 4'h1;
          end
        end
      end
      default: tx_st_d = TX_OFF;
    endcase
    if (pick) begin
      tx_st_d = TX_SEND;
      tx_left_d = frame_bits;
      if (!ctl2_q.tx_on) begin
        tx_st_d = TX_OFF;
      end else if (tx_st_q == TX_SEND && tx_kind_q == K_BRK && !ctl2_q.brk) begin
        // one extra one bit closes the break
        tx_kind_d = K_EXTRA;
        tx_sh_d = 11'h7FF;
        tx_left_d = 4'h1;
      end else if (pre_q || pre_d) begin
        // idle frame is a whole frame of ones
        tx_kind_d = K_PRE;
        tx_sh_d = 11'h7FF;
        pre_d = 1'b0;
      end else if (ctl2_q.brk) begin
        // break is low over the whole frame
        tx_kind_d = K_BRK;
        tx_sh_d = 11'h000;
      end else if (hold_full_q || direct) begin
        // start low, optional ninth bit, stop high
        tx_kind_d = K_DATA;
        tx_sh_d = {1'b1, ctl1_q.wl ? ctl1_q.tx9 : 1'b1, direct ? hwdata[7:0] : hold_q, 1'b0};
        hold_full_d = wr_data && !direct;
        tx_buffer_empty_flag_set = 1'b1;
        // restart the bit timer so the start bit gets a full bit time
        if (direct) begin
          tx_sub_d = 4'h0;
          tx_div_d = tick_div(txf_q, coarse_q.pr_sel, coarse_q.tx_exp) - 16'h0001;
        end
      end else begin
        tx_st_d = TX_REST;
      end
    end
    // set wins over the clear sequence
    tx_buffer_empty_flag_d = tx_buffer_empty_flag_set || (tx_buffer_empty_flag_q && !tx_clr);
    tc_d = tc_set || (tc_q && !tx_clr);
    // line rests high while enabled, released when off
    pin_d = (tx_st_d == TX_SEND) ? tx_sh_d[0] : 1'b1;
    oe_d = (tx_st_d != TX_OFF);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_st_q <= TX_OFF;
      tx_kind_q <= K_PRE;
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_div_q <= 16'h0000;
      pre_q <= 1'b0;
      te_prev_q <= 1'b0;
      hold_full_q <= 1'b0;
      tx_buffer_empty_flag_q <= FLAG_RESET[7];
      tc_q <= FLAG_RESET[6];
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_kind_q <= tx_kind_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_sub_q <= tx_sub_d;
      tx_div_q <= tx_div_d;
      pre_q <= pre_d;
      te_prev_q <= ctl2_q.tx_on;
      hold_full_q <= hold_full_d;
      tx_buffer_empty_flag_q <= tx_buffer_empty_flag_d;
      tc_q <= tc_d;
      serial_out_pin <= pin_d;
      serial_out_oe <= oe_d;
    end
  end

  // ---------------- receiver ----------------
  rx_state_t rx_st_q, rx_st_d;
  logic [15:0] rx_div_q, rx_div_d;
  logic [3:0] rx_sub_q, rx_sub_d, rx_bit_q, rx_bit_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [1:0] smp_q, smp_d;
  logic noise_q, noise_d, arm_q, arm_d, rx9_d;
  logic [7:0] idle_cnt_q, idle_cnt_d, rdr_d;
  logic rtick, maj, odd, accept;
  logic rx_full_flag_set, idle_set, ovr_set, nf_set, fe_set;
  logic rx_full_flag_d, idle_d, ovr_d, nf_d, fe_d;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_sub_d = rx_sub_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    smp_d = smp_q;
    noise_d = noise_q;
    arm_d = arm_q;
    idle_cnt_d = idle_cnt_q;
    rdr_d = rdr_q;
    rx9_d = rx9_q;
    {rx_full_flag_set, idle_set, ovr_set, nf_set, fe_set, wake_evt, accept} = 7'b000_0000;
    rtick = (rx_div_q == 16'h0000);
    rx_div_d = rtick ? tick_div(rxf_q, coarse_q.pr_sel, coarse_q.rx_exp) - 16'h0001
                     : rx_div_q - 16'h0001;
    maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & serial_in_pin) | (smp_q[1] & serial_in_pin);
    odd = !((smp_q[0] == smp_q[1]) && (smp_q[1] == serial_in_pin));
    case (rx_st_q)
      RX_OFF: begin
        if (ctl2_q.rx_on) begin
          rx_st_d = RX_HUNT;
          idle_cnt_d = 8'h00;
          arm_d = 1'b1;
        end
      end
      RX_WAIT_HIGH: begin
        if (rtick && serial_in_pin) begin
          rx_st_d = RX_HUNT;
          idle_cnt_d = 8'h00;
        end
      end
      RX_HUNT: begin
        if (rtick && !serial_in_pin) begin
          rx_st_d = RX_RECV;
          rx_sub_d = 4'h1;
          rx_bit_d = 4'h0;
          noise_d = 1'b0;
        end else if (rtick) begin
          idle_cnt_d = idle_cnt_q + 8'h01;
          // a frame's worth of ones is an idle frame
          if (idle_cnt_d == (ctl1_q.wl ? IDLE_TICKS_9 : IDLE_TICKS_8)) begin
            idle_cnt_d = 8'h00;
            if (arm_q) begin
              arm_d = 1'b0;
              // idle wake clears mute without the idle flag
              if (ctl2_q.mute) wake_evt = !ctl1_q.wake;
              else idle_set = 1'b1;
            end
          end
        end
      end
      RX_RECV: begin
        if (rtick) begin
          rx_sub_d = rx_sub_q + 4'h1;
          if (rx_sub_q == SMP_FIRST) smp_d[0] = serial_in_pin;
          if (rx_sub_q == SMP_MID) smp_d[1] = serial_in_pin;
          if (rx_sub_q == SUB_LAST) rx_bit_d = rx_bit_q + 4'h1;
          if (rx_sub_q == SMP_LAST) begin
            noise_d = noise_q || odd;
            if (rx_bit_q == 4'h0) begin
              if (maj) rx_st_d = RX_HUNT;
            end else if (rx_bit_q == (ctl1_q.wl ? STOP_IDX_9 : STOP_IDX_8)) begin
              rx_st_d = maj ? RX_HUNT : RX_WAIT_HIGH;
              idle_cnt_d = 8'h00;
              arm_d = 1'b1;
              // muted receiver takes a frame only with address-mark wake selected and rx_sh_q[8] set
              accept = !ctl2_q.mute || (ctl1_q.wake && rx_sh_q[8]);
              wake_evt = ctl2_q.mute && accept;
              if (accept && rx_full_flag_q) begin
                ovr_set = 1'b1;
              end else if (accept) begin
                // character and ninth bit to holding
                rdr_d = ctl1_q.wl ? rx_sh_q[7:0] : rx_sh_q[8:1];
                rx9_d = rx_sh_q[8];
                rx_full_flag_set = 1'b1;
                // noise rises with the full flag
                nf_set = noise_d;
                fe_set = !maj;
              end
            end else begin
              // lsb arrives first, shifts toward bit 0
              rx_sh_d = {maj, rx_sh_q[8:1]};
            end
          end
        end
      end
      default: rx_st_d = RX_OFF;
    endcase
    if (!ctl2_q.rx_on) rx_st_d = RX_OFF;
    // disabled receiver holds all receive flags clear
    if (!ctl2_q.rx_on) begin
      {rx_full_flag_d, idle_d, ovr_d, nf_d, fe_d} = 5'b00000;
    end else begin
      // set wins over the read clear sequence
      rx_full_flag_d = rx_full_flag_set || (rx_full_flag_q && !rx_clr);
      idle_d = idle_set || (idle_q && !rx_clr);
      ovr_d = ovr_set || (ovr_q && !rx_clr);
      nf_d = nf_set || (nf_q && !rx_clr);
      fe_d = fe_set || (fe_q && !rx_clr);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_st_q <= RX_OFF;
      rx_div_q <= 16'h0000;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      smp_q <= 2'b11;
      noise_q <= 1'b0;
      arm_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      rdr_q <= 8'h00;
      rx9_q <= 1'b0;
      {rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q} <= FLAG_RESET[5:1];
    end else begin
      rx_st_q <= rx_st_d;
      rx_div_q <= rx_div_d;
      rx_sub_q <= rx_sub_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      smp_q <= smp_d;
      noise_q <= noise_d;
      arm_q <= arm_d;
      idle_cnt_q <= idle_cnt_d;
      rdr_q <= rdr_d;
      rx9_q <= rx9_d;
      {rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q} <= {rx_full_flag_d, idle_d, ovr_d, nf_d, fe_d};
    end
  end

  // ---------------- checks ----------------
  // start and stop levels
  start_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_st_q == TX_SEND && tx_kind_q == K_DATA && tx_left_q == frame_bits |-> !serial_out_pin)
    else $error("start bit not low");
  stop_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_st_q == TX_SEND && tx_kind_q == K_DATA && tx_left_q == 4'h1 |-> serial_out_pin)
    else $error("stop bit not high");
  break_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_st_q == TX_SEND && tx_kind_q == K_BRK |-> !serial_out_pin && serial_out_oe)
    else $error("break frame not low");
  rest_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_st_q != TX_SEND |-> serial_out_pin && (serial_out_oe == (tx_st_q == TX_REST)))
    else $error("resting line wrong");
  idle_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(ctl2_q.tx_on) |=> pre_q || (tx_st_q == TX_SEND && tx_kind_q == K_PRE))
    else $error("no idle frame pending after enable");
  done_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    bit_edge && tx_st_q == TX_SEND && tx_left_q == 4'h1 && tx_kind_q != K_EXTRA |=> tc_q)
    else $error("done flag not set");
  overrun_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(ovr_q) |-> $stable(rdr_q) && rx_full_flag_q) else $error("overrun changed holding");
  mute_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(ctl2_q.mute) && ctl2_q.mute |-> !$rose(rx_full_flag_q) && !$rose(idle_q))
    else $error("flag set while muted");
  rx_off_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !ctl2_q.rx_on |=> !rx_full_flag_q && !idle_q && !ovr_q && !nf_q && !fe_q)
    else $error("receive flags survive disable");
  irq_empty_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_buffer_empty_flag_q && ctl2_q.tx_empty_irq_on && !cpu_irq_mask |-> irq) else $error("empty interrupt missing");
  data_cov: cover property (@(posedge mclk) disable iff (!rst_b) $rose(rx_full_flag_q));
  break_cov: cover property (@(posedge mclk) disable iff (!rst_b) tx_kind_q == K_EXTRA);
  overrun_cov: cover property (@(posedge mclk) disable iff (!rst_b) $rose(ovr_q));
  wake_cov: cover property (@(posedge mclk) disable iff (!rst_b) wake_evt);
endmodule : async_serial_unit

/* verilog/async_serial_pkg.sv */
// constants, register map and carrier types for the asynchronous serial unit
package async_serial_pkg;
  localparam logic [11:0] OFS_FLAG_WORD = 12'h000;
  localparam logic [11:0] OFS_DATA_WINDOW = 12'h004;
  localparam logic [11:0] OFS_CTL1 = 12'h008;
  localparam logic [11:0] OFS_CTL2 = 12'h00C;
  localparam logic [11:0] OFS_COARSE_BAUD = 12'h010;
  localparam logic [11:0] OFS_RX_FINE = 12'h014;
  localparam logic [11:0] OFS_TX_FINE = 12'h018;
  localparam logic [7:0] FLAG_RESET = 8'hC0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // sixteen ticks per bit; majority vote over ticks 7, 8 and 9
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_MID = 4'h8;
  localparam logic [3:0] SMP_LAST = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] STOP_IDX_8 = 4'h9;
  localparam logic [3:0] STOP_IDX_9 = 4'hA;
  localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
  // conventional path divides by 32, i.e. two mclk cycles per 16x tick for each prescaler count
  localparam logic [15:0] CONV_PRE = 16'h0002;
  localparam logic [15:0] PR_A = 16'h0001;
  localparam logic [15:0] PR_B = 16'h0003;
  localparam logic [15:0] PR_C = 16'h0004;
  localparam logic [15:0] PR_D = 16'h000D;

  typedef enum logic [2:0] {SEL_FLAG, SEL_DATA, SEL_CTL1, SEL_CTL2, SEL_COARSE, SEL_RXF, SEL_TXF,
    SEL_NONE} reg_sel_t;
  typedef enum logic [1:0] {TX_OFF, TX_REST, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {K_DATA, K_PRE, K_BRK, K_EXTRA} tx_kind_t;
  typedef enum logic [1:0] {RX_OFF, RX_WAIT_HIGH, RX_HUNT, RX_RECV} rx_state_t;
  typedef struct packed {
    logic tx_buffer_empty_flag; logic tc; logic rx_full_flag; logic idle; logic ovr; logic nf; logic fe; logic rsvd;
  } flags_t;
  typedef struct packed {
    logic rx9; logic tx9; logic rsvd5; logic wl; logic wake; logic [2:0] rsvd;
  } ctl1_t;
  typedef struct packed {
    logic tx_empty_irq_on; logic tx_done_irq_on; logic rx_irq_on; logic line_quiet_irq_on; logic tx_on; logic rx_on; logic mute; logic brk;
  } ctl2_t;
  typedef struct packed {
    logic [1:0] pr_sel; logic [2:0] tx_exp; logic [2:0] rx_exp;
  } coarse_t;
  typedef struct packed {
    logic valid; logic write; reg_sel_t sel;
  } bus_ph_t;
endpackage : async_serial_pkg

/* tb/serial_peer.sv */
// serial equipment model: nrz frames at 16 clocks per bit
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [8:0] seen[$];
  logic [7:0] d;
  initial line_out = 1'b1;
  // lsb first, stop level in bit 8
  initial forever begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk);
      if (i < 8) d[i] = line_in;
      else seen.push_back({line_in, d});
    end
  end
  // stop level chosen by the caller
  task automatic send(input logic [7:0] v, input logic stop);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask : send
endmodule : serial_peer

/* tb/async_serial_unit_tb.sv */
// self-checking bench for the asynchronous serial unit
`timescale 1ns/1ps
module async_serial_unit_tb;
  import async_serial_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic cpu_irq_mask = 1'b0;
  logic hreadyout, hresp, serial_out_pin, serial_out_oe, irq, serial_in_pin, line;
  logic [31:0] hrdata, rd;
  int err_count = 0;
  int checks = 0;
  always #4 mclk = ~mclk;
  // released line is pulled high
  assign line = serial_out_oe ? serial_out_pin : 1'b1;
  async_serial_unit i_async_serial_unit (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .cpu_irq_mask(cpu_irq_mask), .irq(irq));
  serial_peer i_serial_peer (.clk(mclk), .line_in(line), .line_out(serial_in_pin));
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : bus
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, rd);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : rdchk
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rdchk("flag_word", OFS_FLAG_WORD, 32'h0000_00C0);
    rdchk("unmapped", 12'h01C, 32'h0000_0000);
    bus(1'b1, OFS_TX_FINE, 8'h01);
    bus(1'b1, OFS_RX_FINE, 8'h01);
    bus(1'b1, OFS_CTL1, 8'h00);
    bus(1'b1, OFS_CTL2, 8'h08);
    repeat (200) @(posedge mclk);
    rdchk("preamble done", OFS_FLAG_WORD, 32'h0000_00C0);
    bus(1'b1, OFS_DATA_WINDOW, 8'hA5);
    rdchk("empty at once", OFS_FLAG_WORD, 32'h0000_0080);
    bus(1'b1, OFS_DATA_WINDOW, 8'h5A);
    rdchk("holding full", OFS_FLAG_WORD, 32'h0000_0000);
    repeat (400) @(posedge mclk);
    chk("first frame", 32'h0000_01A5, i_serial_peer.seen[0]);
    chk("second frame", 32'h0000_015A, i_serial_peer.seen[1]);
    rdchk("sent flags", OFS_FLAG_WORD, 32'h0000_00C0);
    bus(1'b1, OFS_CTL2, 8'h09);
    repeat (200) @(posedge mclk);
    bus(1'b1, OFS_CTL2, 8'h08);
    chk("break frame", 32'h0000_0000, i_serial_peer.seen[2]);
    repeat (400) @(posedge mclk);
    chk("line rests high", 32'h0000_0001, line);
    // nine-bit word: the peer takes the cleared ninth bit as its stop level
    bus(1'b1, OFS_CTL1, 8'h10);
    bus(1'b1, OFS_DATA_WINDOW, 8'hC3);
    repeat (250) @(posedge mclk);
    chk("ninth bit frame", 32'h0000_00C3, i_serial_peer.seen[3]);
    bus(1'b1, OFS_CTL1, 8'h00);
    bus(1'b1, OFS_CTL2, 8'h88);
    @(negedge mclk);
    chk("empty irq", 32'h0000_0001, irq);
    @(posedge mclk);
    cpu_irq_mask <= 1'b1;
    @(negedge mclk);
    chk("masked irq", 32'h0000_0000, irq);
    bus(1'b1, OFS_CTL2, 8'h0C);
    i_serial_peer.send(8'h3C, 1'b1);
    rdchk("rx full", OFS_FLAG_WORD, 32'h0000_00E0);
    rdchk("rx data", OFS_DATA_WINDOW, 32'h0000_003C);
    repeat (200) @(posedge mclk);
    rdchk("idle flag", OFS_FLAG_WORD, 32'h0000_00D0);
    bus(1'b0, OFS_DATA_WINDOW, 8'h00);
    i_serial_peer.send(8'h11, 1'b1);
    i_serial_peer.send(8'h22, 1'b1);
    rdchk("overrun", OFS_FLAG_WORD, 32'h0000_00E8);
    rdchk("held data", OFS_DATA_WINDOW, 32'h0000_0011);
    rdchk("cleared", OFS_FLAG_WORD, 32'h0000_00C0);
    i_serial_peer.send(8'h55, 1'b0);
    rdchk("frame error", OFS_FLAG_WORD, 32'h0000_00E2);
    rdchk("errored data", OFS_DATA_WINDOW, 32'h0000_0055);
    // muted receiver waits for a word with its top bit set
    bus(1'b1, OFS_CTL1, 8'h08);
    bus(1'b1, OFS_CTL2, 8'h0E);
    i_serial_peer.send(8'h12, 1'b1);
    rdchk("muted flags", OFS_FLAG_WORD, 32'h0000_00C0);
    i_serial_peer.send(8'h93, 1'b1);
    rdchk("woken flags", OFS_FLAG_WORD, 32'h0000_00E0);
    rdchk("mute cleared", OFS_CTL2, 32'h0000_000C);
    bus(1'b1, OFS_CTL2, 8'h08);
    rdchk("rx off", OFS_FLAG_WORD, 32'h0000_00C0);
    rdchk("address word", OFS_DATA_WINDOW, 32'h0000_0093);
    end_sim();
  end
endmodule : async_serial_unit_tb
